//--- logic/agc_carrier_sense_config.sv
// apb register block and gain-reduction sequencer for the agc
`timescale 1ns/1ns
//
// Overview of operation
// - order bit set (reset): reduce first amplifier stage gain first
// - order bit clear: drive second stage to minimum, then reduce first
// - relative threshold code zero disables relative carrier sense
// - relative codes 01,10,11 flag carrier sense on 6,10,14 dB rise
// - absolute threshold signed 1 dB steps around amplitude target
// - absolute code 1000 disables absolute carrier sense
// - absolute compare uses filter amplitude while no gain is cut
// - auxiliary register resets to 0x91, holds and returns writes
// - amplitude target code 0..7 selects 24 dB up to 42 dB goal
module agc_carrier_sense_config
    import agc_cs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire meas_t       meas,
    input  wire gain_req_t   gainReq,
    output gain_set_t        gainSet,
    output logic             carrierSense,
    output logic [7:0]       auxGainControl
);
    localparam logic [2:0] GAIN_MAX = 3'h7;
    localparam logic [2:0] GAIN_MIN = 3'h0;

    typedef struct packed {
        logic [7:0]  csCfg;
        logic [7:0]  aux;
        logic [7:0]  limit;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        gain_set_t   gain;
    } state_t;
    state_t s_q;
    state_t s_d;

    logic csOut;
    logic access;
    logic wrLane;
    logic known;

    // register offsets decode once here and again for writes and for reads
    function automatic logic isMapped(input logic [15:0] a);
        isMapped = (a == OFS_CS_GAIN_ORDER) || (a == OFS_AUX_GAIN_CONTROL)
                || (a == OFS_GAIN_LIMIT_CONFIG)
                || (a == OFS_MEASURE_STATUS);
    endfunction

    cs_detect u_detect (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .meas         (meas),
        .relThr       (s_q.csCfg[POS_REL +: 2]),
        .absThr       (s_q.csCfg[POS_ABS +: 4]),
        .ampTarget    (s_q.limit[POS_TGT +: 3]),
        .carrierSense (csOut)
    );

    // apb slave: one wait state in the access phase, answer registered
    always_comb begin
        access = psel && penable && !s_q.ready;
        wrLane = pwrite && pstrb[0];
        known  = isMapped(paddr);
        s_d = s_q;
        s_d.ready = access;
        s_d.err   = access && !known;
        if (access && wrLane && known) begin
            case (paddr)
                OFS_CS_GAIN_ORDER:
                    s_d.csCfg = pwdata[7:0] & CS_GAIN_ORDER_MASK;
                OFS_AUX_GAIN_CONTROL:
                    s_d.aux = pwdata[7:0];
                OFS_GAIN_LIMIT_CONFIG:
                    s_d.limit = pwdata[7:0];
                default: ;
            endcase
        end
        s_d.rdata = 32'h0;
        if (access && !pwrite) begin
            case (paddr)
                OFS_CS_GAIN_ORDER:     s_d.rdata = {24'h0, s_q.csCfg};
                OFS_AUX_GAIN_CONTROL:  s_d.rdata = {24'h0, s_q.aux};
                OFS_GAIN_LIMIT_CONFIG: s_d.rdata = {24'h0, s_q.limit};
                OFS_MEASURE_STATUS:
                    s_d.rdata = {24'h0, 1'b0, csOut,
                                 s_q.gain.lna1, s_q.gain.lna2};
                default: s_d.rdata = 32'h0;
            endcase
        end
        // gain stepping; reduce wins over increase on a tie
        if (gainReq.reduce) begin
            if (s_q.csCfg[POS_ORDER]) begin
                // first stage first, spill into second at its floor
                if (s_q.gain.lna1 != GAIN_MIN) begin
                    s_d.gain.lna1 = s_q.gain.lna1 - 3'h1;
                end else if (s_q.gain.lna2 != GAIN_MIN) begin
                    s_d.gain.lna2 = s_q.gain.lna2 - 3'h1;
                end
            end else begin
                // second stage fully down before first is touched
                if (s_q.gain.lna2 != GAIN_MIN) begin
                    s_d.gain.lna2 = s_q.gain.lna2 - 3'h1;
                end else if (s_q.gain.lna1 != GAIN_MIN) begin
                    s_d.gain.lna1 = s_q.gain.lna1 - 3'h1;
                end
            end
        end else if (gainReq.increase) begin
            // restore in the reverse order of reduction
            if (s_q.csCfg[POS_ORDER]) begin
                if (s_q.gain.lna2 != GAIN_MAX) begin
                    s_d.gain.lna2 = s_q.gain.lna2 + 3'h1;
                end else if (s_q.gain.lna1 != GAIN_MAX) begin
                    s_d.gain.lna1 = s_q.gain.lna1 + 3'h1;
                end
            end else begin
                if (s_q.gain.lna1 != GAIN_MAX) begin
                    s_d.gain.lna1 = s_q.gain.lna1 + 3'h1;
                end else if (s_q.gain.lna2 != GAIN_MAX) begin
                    s_d.gain.lna2 = s_q.gain.lna2 + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_q.csCfg <= RST_CS_GAIN_ORDER;
            s_q.aux   <= RST_AUX_GAIN;
            s_q.limit <= RST_GAIN_LIMIT;
            s_q.rdata <= 32'h0;
            s_q.ready <= 1'b0;
            s_q.err   <= 1'b0;
            s_q.gain  <= '{lna1: 3'h7, lna2: 3'h7};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops (carrier sense flopped in detector)
    assign prdata         = s_q.rdata;
    assign pready         = s_q.ready;
    assign pslverr        = s_q.err;
    assign gainSet        = s_q.gain;
    assign auxGainControl = s_q.aux;
    assign carrierSense   = csOut;

    // checks
    AST_ORDER_FIRST: assert property (@(posedge clk_sys) disable iff (reset)
        gainReq.reduce && s_q.csCfg[POS_ORDER] && s_q.gain.lna1 != 3'h0
        |=> s_q.gain.lna2 == $past(s_q.gain.lna2))
        else $error("second stage cut while first had gain");
    AST_ORDER_SECOND: assert property (@(posedge clk_sys) disable iff (reset)
        gainReq.reduce && !s_q.csCfg[POS_ORDER] && s_q.gain.lna2 != 3'h0
        |=> s_q.gain.lna1 == $past(s_q.gain.lna1))
        else $error("first stage cut before second at minimum");
    AST_REL_OFF: assert property (@(posedge clk_sys) disable iff (reset)
        meas.valid && s_q.csCfg[5:4] == 2'h0 && s_q.csCfg[3:0] == 4'h8
        |=> !carrierSense)
        else $error("carrier sense with both detectors off");
    AST_ABS_OFF: assert property (@(posedge clk_sys) disable iff (reset)
        meas.valid && s_q.csCfg[3:0] == 4'h8 && s_q.csCfg[5:4] == 2'h0
        ##1 !meas.valid |-> !carrierSense)
        else $error("absolute detect active at disable code");
    AST_ABS_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
        meas.valid && !meas.gainCut && s_q.csCfg[5:0] == 6'h00
        && s_q.limit[2:0] == 3'h0 && meas.filterAmp >= 8'h18
        |=> carrierSense)
        else $error("no carrier sense at target level");
    AST_TGT_42: assert property (@(posedge clk_sys) disable iff (reset)
        meas.valid && !meas.gainCut && s_q.csCfg[5:0] == 6'h00
        && s_q.limit[2:0] == 3'h7 && meas.filterAmp == 8'h29
        |=> !carrierSense)
        else $error("carrier sense below 42 dB target");
    AST_RAW_AMP: assert property (@(posedge clk_sys) disable iff (reset)
        meas.valid && !meas.gainCut && s_q.csCfg[5:0] == 6'h07
        && s_q.limit[2:0] == 3'h0 && meas.filterAmp == 8'h1F
        |=> carrierSense)
        else $error("filter amplitude not used before gain cut");
    AST_TOP_BIT: assert property (@(posedge clk_sys) disable iff (reset)
        !s_q.csCfg[7])
        else $error("reserved bit set");
    AST_AUX_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
        psel && penable && pwrite && pstrb[0] && !pready
        && paddr == OFS_AUX_GAIN_CONTROL
        |=> auxGainControl == $past(pwdata[7:0]))
        else $error("aux register did not take write");
    AST_REL_STEP: assert property (@(posedge clk_sys) disable iff (reset)
        meas.valid && s_q.csCfg[5:0] == 6'h18 && meas.level == 8'h00
        ##1 meas.valid && meas.level == 8'h0A && s_q.csCfg[5:0] == 6'h18
        |=> carrierSense)
        else $error("relative 10 dB rise not flagged");

    COV_READ: cover property (@(posedge clk_sys) disable iff (reset)
        pready && !pslverr);
    COV_ERR: cover property (@(posedge clk_sys) disable iff (reset) pslverr);
    COV_CS: cover property (@(posedge clk_sys) disable iff (reset)
        $rose(carrierSense));
    COV_SPILL: cover property (@(posedge clk_sys) disable iff (reset)
        gainReq.reduce && s_q.gain.lna1 == 3'h0 && s_q.gain.lna2 != 3'h0);
endmodule

//--- logic/agc_cs_pkg.sv
// package: register map, field layout, reset values and carrier types
package agc_cs_pkg;
    // register byte addresses (printed offsets are byte addresses)
    localparam logic [15:0] OFS_GAIN_LIMIT_CONFIG = 16'hDF17;
    localparam logic [15:0] OFS_CS_GAIN_ORDER     = 16'hDF18;
    localparam logic [15:0] OFS_AUX_GAIN_CONTROL  = 16'hDF19;
    localparam logic [15:0] OFS_MEASURE_STATUS    = 16'hDF1C;
    // field positions
    localparam int POS_ORDER = 6;
    localparam int POS_REL   = 4;
    localparam int POS_ABS   = 0;
    localparam int POS_TGT   = 0;
    // reset values
    localparam logic [7:0] RST_CS_GAIN_ORDER = 8'h40;
    localparam logic [7:0] RST_AUX_GAIN      = 8'h91;
    localparam logic [7:0] RST_GAIN_LIMIT    = 8'h03;
    // threshold codes and constants
    localparam logic [3:0] ABS_DISABLE_CODE = 4'h8;
    localparam logic [7:0] REL_STEP_01 = 8'h06;
    localparam logic [7:0] REL_STEP_10 = 8'h0A;
    localparam logic [7:0] REL_STEP_11 = 8'h0E;
    localparam logic [7:0] CS_GAIN_ORDER_MASK = 8'h7F;

    // measurement sample coming from the receive chain
    typedef struct packed {
        logic       valid;
        logic [7:0] level;      // signal strength in dB
        logic [7:0] filterAmp;  // channel filter amplitude in dB
        logic       gainCut;    // agc has reduced some gain
    } meas_t;

    // gain stage request to the front end
    typedef struct packed {
        logic reduce;   // ask for one step less gain
        logic increase; // ask for one step more gain
    } gain_req_t;

    typedef struct packed {
        logic [2:0] lna1;
        logic [2:0] lna2;
    } gain_set_t;
endpackage

//--- logic/cs_detect.sv
// carrier-sense comparator: relative and absolute thresholds
`timescale 1ns/1ns
module cs_detect
    import agc_cs_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire meas_t      meas,
    input  wire logic [1:0] relThr,
    input  wire logic [3:0] absThr,
    input  wire logic [2:0] ampTarget,
    output logic            carrierSense
);
    typedef struct packed {
        logic [7:0] baseLevel;
        logic       haveBase;
        logic       cs;
    } st_t;
    st_t s_q;
    st_t s_d;

    // amplitude goal in dB per target code
    function automatic logic [7:0] targetDb(input logic [2:0] c);
        case (c)
            3'h0: targetDb = 8'h18;
            3'h1: targetDb = 8'h1B;
            3'h2: targetDb = 8'h1E;
            3'h3: targetDb = 8'h21;
            3'h4: targetDb = 8'h24;
            3'h5: targetDb = 8'h26;
            3'h6: targetDb = 8'h28;
            default: targetDb = 8'h2A;
        endcase
    endfunction

    function automatic logic [7:0] relStep(input logic [1:0] c);
        case (c)
            2'h1: relStep = REL_STEP_01;
            2'h2: relStep = REL_STEP_10;
            default: relStep = REL_STEP_11;
        endcase
    endfunction

    logic [8:0] absLimit;
    logic [7:0] measure;
    logic       absHit;
    logic       relHit;

    // compare and latch on each valid sample
    always_comb begin
        // before any gain cut the measure is the raw filter amplitude
        measure  = meas.gainCut ? meas.level : meas.filterAmp;
        absLimit = 9'({1'b0, targetDb(ampTarget)})
                 + 9'({{5{absThr[3]}}, absThr});
        absHit   = (absThr != ABS_DISABLE_CODE)
                 && !absLimit[8] && ({1'b0, measure} >= absLimit);
        relHit   = (relThr != 2'h0) && s_q.haveBase
                 && (9'({1'b0, meas.level}) >=
                     9'({1'b0, s_q.baseLevel})
                     + 9'({1'b0, relStep(relThr)}));
        s_d = s_q;
        if (meas.valid) begin
            s_d.cs = absHit || relHit;
            // base tracks the quiet level so a rise is measured against it
            if (!relHit) begin
                s_d.baseLevel = meas.level;
            end
            s_d.haveBase = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign carrierSense = s_q.cs;
endmodule

//--- test/tb.sv
// self-checking bench for the agc carrier-sense register block
`timescale 1ns/1ns
module tb;
    import agc_cs_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [15:0] paddr   = 16'h0000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    meas_t       meas    = '0;
    gain_req_t   gainReq = '0;
    gain_set_t   gainSet;
    logic        carrierSense;
    logic [7:0]  auxGainControl;
    int          num_errors = 0;
    int          n_tests    = 0;
    int          step[3] = '{6, 10, 14};
    int          thDb[11] = '{24, 27, 30, 33, 36, 38, 40, 42, 32, 17, 49};
    int          tgt[11]  = '{0, 1, 2, 3, 4, 5, 6, 7, 3, 0, 7};
    int          absC[11] = '{0, 0, 0, 0, 0, 0, 0, 0, 15, 9, 7};

    agc_carrier_sense_config i_dut (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
        .gainReq(gainReq), .gainSet(gainSet), .carrierSense(carrierSense),
        .auxGainControl(auxGainControl)
    );

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; waits for pready under a bounded count
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        begin
            @(posedge clk_sys);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= {24'h000000, d};
            @(posedge clk_sys);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (pready !== 1'b1 && n < 20);
            // a slave that never answers counts against the run
            if (pready !== 1'b1) begin
                num_errors++;
                $display("Error pready expected 1 seen %b", pready);
            end
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] x,
                         input logic xe);
        logic [31:0] r;
        logic        e;
        begin
            apb(1'b0, a, 8'h00, r, e);
            chk("prdata", r, {24'h000000, x});
            chk("pslverr", {31'h0, e}, {31'h0, xe});
        end
    endtask

    // hold a gain request for n edges, then compare both stage codes
    task automatic gain(input logic r, input logic i, input int n,
                        input logic [5:0] x);
        @(posedge clk_sys);
        gainReq <= '{reduce: r, increase: i};
        repeat (n) @(posedge clk_sys);
        gainReq <= '0;
        @(negedge clk_sys);
        chk("gainSet", {26'h0, gainSet}, {26'h0, x});
    endtask

    // one measurement sample; carrier sense is checked a cycle later
    task automatic sm(input int lvl, input int amp, input logic cut,
                      input logic x);
        @(posedge clk_sys);
        meas <= '{valid: 1'b1, level: 8'(lvl), filterAmp: 8'(amp),
                  gainCut: cut};
        @(posedge clk_sys);
        meas.valid <= 1'b0;
        @(negedge clk_sys);
        chk("carrierSense", {31'h0, carrierSense}, {31'h0, x});
    endtask

    // watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        chk("gainSet", {26'h0, gainSet}, 32'h0000003F);
        chk("auxGainControl", {24'h0, auxGainControl}, 32'h91);
        rdchk(OFS_GAIN_LIMIT_CONFIG, 8'h03, 1'b0);
        rdchk(OFS_CS_GAIN_ORDER, 8'h40, 1'b0);
        rdchk(OFS_AUX_GAIN_CONTROL, 8'h91, 1'b0);
        wr(OFS_CS_GAIN_ORDER, 8'hFF);
        rdchk(OFS_CS_GAIN_ORDER, 8'h7F, 1'b0);
        wr(OFS_AUX_GAIN_CONTROL, 8'h5A);
        rdchk(OFS_AUX_GAIN_CONTROL, 8'h5A, 1'b0);
        chk("auxGainControl", {24'h0, auxGainControl}, 32'h5A);
        // unmapped place: error flagged, write dropped, reads zero
        wr(16'hDF1A, 8'h12);
        rdchk(16'hDF1A, 8'h00, 1'b1);
        // gain order: first stage first, then second stage to minimum
        wr(OFS_CS_GAIN_ORDER, 8'h48);
        gain(1'b1, 1'b0, 1, {3'h6, 3'h7});
        gain(1'b0, 1'b1, 1, {3'h7, 3'h7});
        wr(OFS_CS_GAIN_ORDER, 8'h08);
        gain(1'b1, 1'b0, 7, {3'h7, 3'h0});
        gain(1'b1, 1'b0, 1, {3'h6, 3'h0});
        // status word: no carrier sense yet, stages at 6 and 0
        rdchk(OFS_MEASURE_STATUS, 8'h30, 1'b0);
        // relative rise: one dB short misses, the exact step hits
        for (int c = 1; c < 4; c++) begin
            wr(OFS_CS_GAIN_ORDER, 8'(c * 16 + 8));
            sm(0, 0, 1'b1, 1'b0);
            sm(step[c-1] - 1, 0, 1'b1, 1'b0);
            sm(2 * step[c-1] - 1, 0, 1'b1, 1'b1);
        end
        wr(OFS_CS_GAIN_ORDER, 8'h08);
        sm(0, 0, 1'b1, 1'b0);
        sm(60, 0, 1'b1, 1'b0);
        // absolute threshold around every amplitude target
        for (int k = 0; k < 11; k++) begin
            wr(OFS_GAIN_LIMIT_CONFIG, 8'(tgt[k]));
            wr(OFS_CS_GAIN_ORDER, 8'(absC[k]));
            sm(0, thDb[k], 1'b0, 1'b1);
            sm(0, thDb[k] - 1, 1'b0, 1'b0);
            sm(thDb[k], 0, 1'b1, 1'b1);
            sm(thDb[k] - 1, 255, 1'b1, 1'b0);
        end
        // highest code on the lowest target: 31 dB on raw amplitude
        wr(OFS_GAIN_LIMIT_CONFIG, 8'h00);
        wr(OFS_CS_GAIN_ORDER, 8'h07);
        sm(0, 31, 1'b0, 1'b1);
        wr(OFS_CS_GAIN_ORDER, 8'h08);
        sm(0, 255, 1'b0, 1'b0);
        sm(255, 0, 1'b1, 1'b0);
        report_and_stop();
    end
endmodule
